// file: core/rrs_defs.svh
// register map, field positions, reset values, mode codes and timing figures
`ifndef RRS_DEFS_SVH
`define RRS_DEFS_SVH

// register byte offsets
`define RRS_OFF_CMD 8'h00
`define RRS_OFF_RXCFG 8'h04
`define RRS_OFF_SEQCFG 8'h08
`define RRS_OFF_OPMODE 8'h0c
`define RRS_OFF_STATUS 8'h10

// command register bits
`define RRS_CMD_NORELOCK 0
`define RRS_CMD_RELOCK 1
`define RRS_CMD_LAUNCH 2
`define RRS_CMD_STOP 3

// receiver config fields
`define RRS_RX_AUTO_LSB 0
`define RRS_RX_AUTO_MSB 1
`define RRS_RX_COLL_EN 2
`define RRS_RX_AFC_EN 3
`define RRS_RX_STEP_LSB 8
`define RRS_RX_STEP_MSB 15
`define RRS_RX_GAP_LSB 16
`define RRS_RX_GAP_MSB 23
`define RRS_RXCFG_RESET 32'h0000_0a00

// sequencer config fields
`define RRS_SQ_IDLE_PWR 0
`define RRS_SQ_START_LSB 1
`define RRS_SQ_START_MSB 2
`define RRS_SQ_LP_CHOICE 3
`define RRS_SQ_IDLE_EXIT 4
`define RRS_SQ_FROM_TX 5
`define RRS_SQ_FROM_RX_LSB 6
`define RRS_SQ_FROM_RX_MSB 8
`define RRS_SQ_FROM_TO_LSB 9
`define RRS_SQ_FROM_TO_MSB 10
`define RRS_SQ_FROM_HELD_LSB 11
`define RRS_SQ_FROM_HELD_MSB 13
`define RRS_SEQCFG_RESET 32'h0000_0000

// op mode register: mode bits and modulation family bit
`define RRS_OP_MODE_LSB 0
`define RRS_OP_MODE_MSB 2
`define RRS_OP_SPREAD 7
`define RRS_OPMODE_RESET 32'h0000_0001

// chip mode codes
`define RRS_MODE_SLEEP 3'h0
`define RRS_MODE_STBY 3'h1
`define RRS_MODE_FSTX 3'h2
`define RRS_MODE_TX 3'h3
`define RRS_MODE_FSRX 3'h4
`define RRS_MODE_RX 3'h5

// timing: clock period, gap unit, synthesizer lock, mode settling
`define RRS_CLK_PS 4000
`define RRS_GAP_UNIT_NS 1000
`define RRS_PLL_LOCK_US 100
`define RRS_SETTLE_NS 2000

`endif

// file: core/rrs_pkg.sv
// types shared by the restart and sequencer block
package rrs_pkg;
  typedef enum logic [6:0] {
    RRS_SEQ_OFF = 7'b0000001,
    RRS_SEQ_IDLE = 7'b0000010,
    RRS_SEQ_TX = 7'b0000100,
    RRS_SEQ_RX = 7'b0001000,
    RRS_SEQ_HELD = 7'b0010000,
    RRS_SEQ_LPSEL = 7'b0100000,
    RRS_SEQ_RXTO = 7'b1000000
  } rrs_seq_t;
endpackage

// file: core/rrs_core.sv
// receiver restart engine and top-level mode sequencer with apb registers
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - restart command ignored unless mode settled flag is 1 at write
// - auto-rearm field 00: no automatic restart after a valid packet
// - field 01: after fifo emptied post payload, restart after programmed gap
// - field 10: like 01 plus extra synthesizer lock delay
// - in receive mode a sudden signal strength rise restarts the receiver
// - collision restart works only while collision enable bit is 1
// - collision rise threshold is programmable in 1 dB steps
// - sequencer runs only in fsk/ook, never in spread-spectrum mode
// - launch bit in sleep or standby starts sequencer, records initial mode
// - stop bit forces sequencer off from any state
// - idle holds standby or sleep and reacts only to first timer
// - held state keeps receiver on; transmit and receive states enable their paths
// - any of the three receive timeouts raises a receive-timeout event
// - low-power choice state is transitory: goes to off or idle
// - idle power select 0 gives standby, 1 gives sleep
// - first timer in idle goes to transmit when select 0, receive when 1
// - second timer in receive always goes to low-power choice
// - low-power choice 0 selects off with initial mode, 1 selects idle
`include "rrs_defs.svh"

module rrs_core
  import rrs_pkg::*;
#(
  parameter int PLL_LOCK_CYC = (`RRS_PLL_LOCK_US * 1000000 + `RRS_CLK_PS - 1) / `RRS_CLK_PS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic payload_complete_event,
  input wire logic fifo_empty,
  input wire logic fifo_threshold_irq,
  input wire logic packet_sent_irq,
  input wire logic crc_ok_irq,
  input wire logic rssi_irq,
  input wire logic sync_irq,
  input wire logic preamble_irq,
  input wire logic level_timeout,
  input wire logic preamble_timeout,
  input wire logic syncword_timeout,
  input wire logic first_interval_timer,
  input wire logic second_interval_timer,
  input wire logic [7:0] rssi_level,
  output logic [2:0] chip_mode,
  output logic rx_restart_pulse,
  output logic rx_relock_pulse,
  output logic mode_settled_flag,
  output logic [6:0] seq_state
);

  localparam int GAP_UNIT_CYC = (`RRS_GAP_UNIT_NS * 1000) / `RRS_CLK_PS;
  localparam int SETTLE_CYC = (`RRS_SETTLE_NS * 1000 + `RRS_CLK_PS - 1) / `RRS_CLK_PS;

  logic [31:0] rxcfg_reg;
  logic [31:0] seqcfg_reg;
  logic [31:0] opmode_reg;
  logic [3:0] cmd_reg;
  logic [11:0] settle_reg;
  logic [31:0] gap_cnt_reg;
  logic gap_run_reg;
  logic gap_relock_reg;
  logic armed_reg;
  logic [7:0] rssi_prev_reg;
  logic [2:0] init_mode_reg;
  logic start_wait_reg;
  logic seq_restart_reg;
  logic seq_relock_reg;
  rrs_seq_t seq_reg;
  rrs_seq_t seq_next;
  logic seq_restore;
  logic [2:0] seq_mode;

  // bus access qualifiers
  logic wr_en;
  logic rd_en;
  logic in_rx;
  logic rx_timeout;
  logic spread_mode;
  logic collision;
  logic [8:0] rssi_rise;
  logic [1:0] auto_sel;
  logic [2:0] from_rx;
  logic [1:0] from_to;
  logic [2:0] from_held;

  assign wr_en = psel & penable & pwrite & pready;
  assign rd_en = psel & penable & ~pwrite & ~pready;
  assign in_rx = (chip_mode == `RRS_MODE_RX);
  assign rx_timeout = level_timeout | preamble_timeout | syncword_timeout;
  assign spread_mode = opmode_reg[`RRS_OP_SPREAD];
  assign auto_sel = rxcfg_reg[`RRS_RX_AUTO_MSB:`RRS_RX_AUTO_LSB];
  assign from_rx = seqcfg_reg[`RRS_SQ_FROM_RX_MSB:`RRS_SQ_FROM_RX_LSB];
  assign from_to = seqcfg_reg[`RRS_SQ_FROM_TO_MSB:`RRS_SQ_FROM_TO_LSB];
  assign from_held = seqcfg_reg[`RRS_SQ_FROM_HELD_MSB:`RRS_SQ_FROM_HELD_LSB];

  // collision: rise over last sample beyond the 1 dB step threshold
  assign rssi_rise = {1'b0, rssi_level} - {1'b0, rssi_prev_reg};
  assign collision = in_rx & rxcfg_reg[`RRS_RX_COLL_EN] & ~rssi_rise[8]
    & (rssi_rise[7:0] > rxcfg_reg[`RRS_RX_STEP_MSB:`RRS_RX_STEP_LSB]);

  // apb handshake: one wait state, unmapped offsets answer with an error
  always_ff @(posedge clock) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & (paddr > `RRS_OFF_STATUS | paddr[1:0] != 2'h0);
    end
  end

  // read data mux
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (rd_en) begin
      case (paddr)
        `RRS_OFF_CMD: prdata <= {28'h0, cmd_reg};
        `RRS_OFF_RXCFG: prdata <= rxcfg_reg;
        `RRS_OFF_SEQCFG: prdata <= seqcfg_reg;
        `RRS_OFF_OPMODE: prdata <= opmode_reg;
        `RRS_OFF_STATUS: prdata <= {18'h0, seq_reg, gap_run_reg, armed_reg,
                                    mode_settled_flag, chip_mode, 1'b0};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge clock) begin
    if (rst) begin
      rxcfg_reg <= `RRS_RXCFG_RESET;
      seqcfg_reg <= `RRS_SEQCFG_RESET;
    end else if (wr_en) begin
      if (paddr == `RRS_OFF_RXCFG) rxcfg_reg <= {8'h0, pwdata[23:0]};
      if (paddr == `RRS_OFF_SEQCFG) seqcfg_reg <= {18'h0, pwdata[13:0]};
    end
  end

  // op mode: host writes; sequencer restore of the initial mode wins
  always_ff @(posedge clock) begin
    if (rst) begin
      opmode_reg <= `RRS_OPMODE_RESET;
    end else if (seq_restore) begin
      opmode_reg[`RRS_OP_MODE_MSB:`RRS_OP_MODE_LSB] <= init_mode_reg;
    end else if (wr_en && paddr == `RRS_OFF_OPMODE) begin
      opmode_reg <= {24'h0, pwdata[7], 4'h0, pwdata[2:0]};
    end
  end

  // one-shot commands: taken only when acceptable, cleared once consumed
  always_ff @(posedge clock) begin
    if (rst) begin
      cmd_reg <= 4'h0;
    end else if (wr_en && paddr == `RRS_OFF_CMD) begin
      cmd_reg[`RRS_CMD_NORELOCK] <= pwdata[`RRS_CMD_NORELOCK] & mode_settled_flag
        & in_rx;
      cmd_reg[`RRS_CMD_RELOCK] <= pwdata[`RRS_CMD_RELOCK] & mode_settled_flag & in_rx;
      cmd_reg[`RRS_CMD_LAUNCH] <= pwdata[`RRS_CMD_LAUNCH];
      cmd_reg[`RRS_CMD_STOP] <= pwdata[`RRS_CMD_STOP];
    end else begin
      cmd_reg <= 4'h0;
    end
  end

  // mode settling: flag drops on any mode change or restart
  always_ff @(posedge clock) begin
    if (rst) begin
      settle_reg <= 12'h0;
      mode_settled_flag <= 1'b0;
    end else if (seq_mode != chip_mode || rx_restart_pulse || rx_relock_pulse) begin
      settle_reg <= 12'h0;
      mode_settled_flag <= 1'b0;
    end else if (settle_reg == 12'(SETTLE_CYC)) begin
      mode_settled_flag <= 1'b1;
    end else begin
      settle_reg <= settle_reg + 12'h1;
    end
  end

  // chip mode follows the sequencer or the host setting
  always_ff @(posedge clock) begin
    if (rst) begin
      chip_mode <= `RRS_MODE_STBY;
    end else begin
      chip_mode <= seq_mode;
    end
  end

  // signal strength history for the collision detector
  always_ff @(posedge clock) begin
    if (rst) begin
      rssi_prev_reg <= 8'h0;
    end else begin
      rssi_prev_reg <= rssi_level;
    end
  end

  // auto rearm: arm on payload, start gap timer once fifo drains
  always_ff @(posedge clock) begin
    if (rst) begin
      armed_reg <= 1'b0;
      gap_run_reg <= 1'b0;
      gap_relock_reg <= 1'b0;
      gap_cnt_reg <= 32'h0;
    end else if (!in_rx || auto_sel == 2'h0 || auto_sel == 2'h3) begin
      armed_reg <= 1'b0;
      gap_run_reg <= 1'b0;
    end else if (armed_reg && fifo_empty) begin
      armed_reg <= 1'b0;
      gap_run_reg <= 1'b1;
      gap_relock_reg <= (auto_sel == 2'h2);
      gap_cnt_reg <= 32'(rxcfg_reg[`RRS_RX_GAP_MSB:`RRS_RX_GAP_LSB]) * 32'(GAP_UNIT_CYC)
        + ((auto_sel == 2'h2) ? 32'(PLL_LOCK_CYC) : 32'h0);
    end else if (gap_run_reg) begin
      if (gap_cnt_reg == 32'h0 || collision) gap_run_reg <= 1'b0;
      else gap_cnt_reg <= gap_cnt_reg - 32'h1;
    end else if (payload_complete_event) begin
      armed_reg <= 1'b1;
    end
  end

  // restart pulses to the receive chain
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_restart_pulse <= 1'b0;
      rx_relock_pulse <= 1'b0;
    end else begin
      rx_restart_pulse <= cmd_reg[`RRS_CMD_NORELOCK] | collision
        | (gap_run_reg & gap_cnt_reg == 32'h0 & ~gap_relock_reg)
        | (seq_restart_reg & ~seq_relock_reg);
      rx_relock_pulse <= cmd_reg[`RRS_CMD_RELOCK]
        | (gap_run_reg & gap_cnt_reg == 32'h0 & gap_relock_reg)
        | (seq_restart_reg & seq_relock_reg);
    end
  end

  // sequencer next state
  always_comb begin
    seq_next = seq_reg;
    seq_restore = 1'b0;
    case (seq_reg)
      RRS_SEQ_OFF: begin
        if (cmd_reg[`RRS_CMD_LAUNCH] || start_wait_reg) begin
          case (seqcfg_reg[`RRS_SQ_START_MSB:`RRS_SQ_START_LSB])
            2'h0: seq_next = RRS_SEQ_LPSEL;
            2'h1: seq_next = RRS_SEQ_RX;
            2'h2: seq_next = RRS_SEQ_TX;
            default: seq_next = fifo_threshold_irq ? RRS_SEQ_TX : RRS_SEQ_OFF;
          endcase
        end
      end
      RRS_SEQ_IDLE: begin
        if (first_interval_timer) begin
          seq_next = seqcfg_reg[`RRS_SQ_IDLE_EXIT] ? RRS_SEQ_RX : RRS_SEQ_TX;
        end
      end
      RRS_SEQ_TX: begin
        if (packet_sent_irq) begin
          seq_next = seqcfg_reg[`RRS_SQ_FROM_TX] ? RRS_SEQ_RX : RRS_SEQ_LPSEL;
        end
      end
      RRS_SEQ_RX: begin
        if (second_interval_timer) seq_next = RRS_SEQ_LPSEL;
        else if (rx_timeout) seq_next = RRS_SEQ_RXTO;
        else begin
          case (from_rx)
            3'h1: if (payload_complete_event) seq_next = RRS_SEQ_HELD;
            3'h2: if (payload_complete_event) seq_next = RRS_SEQ_LPSEL;
            3'h3: begin
              if (crc_ok_irq) seq_next = RRS_SEQ_HELD;
              else if (payload_complete_event) seq_next = RRS_SEQ_RXTO;
            end
            3'h4: if (rssi_irq) seq_next = RRS_SEQ_OFF;
            3'h5: if (sync_irq) seq_next = RRS_SEQ_OFF;
            3'h6: if (preamble_irq) seq_next = RRS_SEQ_OFF;
            default: seq_next = RRS_SEQ_RX;
          endcase
        end
      end
      RRS_SEQ_RXTO: begin
        case (from_to)
          2'h0: seq_next = RRS_SEQ_RX;
          2'h1: seq_next = RRS_SEQ_TX;
          2'h2: seq_next = RRS_SEQ_LPSEL;
          default: seq_next = RRS_SEQ_OFF;
        endcase
      end
      RRS_SEQ_HELD: begin
        case (from_held)
          3'h0: seq_next = RRS_SEQ_OFF;
          3'h1: if (fifo_empty) seq_next = RRS_SEQ_TX;
          3'h2: seq_next = RRS_SEQ_LPSEL;
          3'h3: seq_next = RRS_SEQ_RX;
          3'h4: seq_next = RRS_SEQ_RX;
          default: seq_next = RRS_SEQ_HELD;
        endcase
      end
      RRS_SEQ_LPSEL: begin
        seq_next = seqcfg_reg[`RRS_SQ_LP_CHOICE] ? RRS_SEQ_IDLE : RRS_SEQ_OFF;
        seq_restore = ~seqcfg_reg[`RRS_SQ_LP_CHOICE];
      end
      default: seq_next = RRS_SEQ_OFF;
    endcase
    if (cmd_reg[`RRS_CMD_STOP] || spread_mode) begin
      seq_next = RRS_SEQ_OFF;
      seq_restore = 1'b0;
    end
  end

  // chip mode demanded by the sequencer state
  always_comb begin
    case (seq_reg)
      RRS_SEQ_IDLE: seq_mode = seqcfg_reg[`RRS_SQ_IDLE_PWR] ? `RRS_MODE_SLEEP
                                                          : `RRS_MODE_STBY;
      RRS_SEQ_TX: seq_mode = `RRS_MODE_TX;
      RRS_SEQ_RX: seq_mode = `RRS_MODE_RX;
      RRS_SEQ_HELD: seq_mode = `RRS_MODE_RX;
      RRS_SEQ_RXTO: seq_mode = `RRS_MODE_RX;
      RRS_SEQ_LPSEL: seq_mode = chip_mode;
      default: seq_mode = opmode_reg[`RRS_OP_MODE_MSB:`RRS_OP_MODE_LSB];
    endcase
  end

  // sequencer state, launch latch and initial mode capture
  always_ff @(posedge clock) begin
    if (rst) begin
      seq_reg <= RRS_SEQ_OFF;
      init_mode_reg <= `RRS_MODE_STBY;
      start_wait_reg <= 1'b0;
    end else begin
      seq_reg <= seq_next;
      if (seq_reg == RRS_SEQ_OFF && cmd_reg[`RRS_CMD_LAUNCH] && !spread_mode
          && !cmd_reg[`RRS_CMD_STOP]
          && (chip_mode == `RRS_MODE_SLEEP || chip_mode == `RRS_MODE_STBY)) begin
        init_mode_reg <= chip_mode;
        start_wait_reg <= (seqcfg_reg[`RRS_SQ_START_MSB:`RRS_SQ_START_LSB] == 2'h3);
      end else if (seq_next != RRS_SEQ_OFF || cmd_reg[`RRS_CMD_STOP] || spread_mode) begin
        start_wait_reg <= 1'b0;
      end
    end
  end

  // restart requests raised by sequencer moves back into receive
  always_ff @(posedge clock) begin
    if (rst) begin
      seq_restart_reg <= 1'b0;
      seq_relock_reg <= 1'b0;
    end else begin
      seq_restart_reg <= (seq_reg == RRS_SEQ_RXTO || seq_reg == RRS_SEQ_HELD)
        && seq_next == RRS_SEQ_RX;
      seq_relock_reg <= (seq_reg == RRS_SEQ_HELD && from_held == 3'h3)
        || rxcfg_reg[`RRS_RX_AFC_EN];
    end
  end

  // state shown on the pins
  always_ff @(posedge clock) begin
    if (rst) begin
      seq_state <= 7'h01;
    end else begin
      seq_state <= seq_next;
    end
  end

endmodule

// file: verif/rrs_core_assertions.sv
// concurrent checks on the restart and sequencer ports
`timescale 1ns/1ps
`include "rrs_defs.svh"
module rrs_core_checker
  import rrs_pkg::*;
#(
  parameter int PLL_LOCK_CYC = 20
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic first_interval_timer,
  input wire logic [2:0] chip_mode,
  input wire logic rx_restart_pulse,
  input wire logic rx_relock_pulse,
  input wire logic mode_settled_flag,
  input wire logic [6:0] seq_state
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic cmd_wr;
  // command write at its taking edge
  assign cmd_wr = psel && penable && pready && pwrite && paddr == `RRS_OFF_CMD;
  chk_restart_taken: assert property (
    cmd_wr && pwdata[0] && mode_settled_flag && chip_mode == `RRS_MODE_RX
    |-> ##2 rx_restart_pulse) else $error("restart not issued");
  chk_relock_taken: assert property (
    cmd_wr && pwdata[1] && mode_settled_flag && chip_mode == `RRS_MODE_RX
    |-> ##2 rx_relock_pulse) else $error("relock not issued");
  chk_restart_dropped: assert property (
    cmd_wr && pwdata[0] && !mode_settled_flag |-> ##2 !rx_restart_pulse)
    else $error("unsettled restart taken");
  chk_pulse_single: assert property (
    rx_restart_pulse |=> !rx_restart_pulse) else $error("restart pulse too long");
  chk_lpsel_brief: assert property (
    seq_state == RRS_SEQ_LPSEL |=> seq_state == RRS_SEQ_OFF || seq_state == RRS_SEQ_IDLE)
    else $error("low power choice lingered");
  chk_idle_mode: assert property (
    (seq_state == RRS_SEQ_IDLE) [*2] |-> chip_mode == `RRS_MODE_SLEEP
    || chip_mode == `RRS_MODE_STBY) else $error("idle not low power");
  chk_rx_mode: assert property (
    (seq_state == RRS_SEQ_RX) [*2] |-> chip_mode == `RRS_MODE_RX)
    else $error("receive state without receiver");
  chk_idle_t1: assert property (
    seq_state == RRS_SEQ_IDLE && first_interval_timer
    |-> ##[1:2] (seq_state == RRS_SEQ_RX || seq_state == RRS_SEQ_TX))
    else $error("idle ignored first timer");
  cov_restart: cover property (rx_restart_pulse);
  cov_relock: cover property (rx_relock_pulse);
  cov_lpsel: cover property (seq_state == RRS_SEQ_LPSEL);
endmodule

bind rrs_core rrs_core_checker #(.PLL_LOCK_CYC(PLL_LOCK_CYC)) rrs_core_checker_i (
  .clock, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
  .first_interval_timer, .chip_mode, .rx_restart_pulse, .rx_relock_pulse,
  .mode_settled_flag, .seq_state
);

// file: verif/rrs_host_model.sv
// host model: apb master and command writes
`timescale 1ns/1ps
`include "rrs_defs.svh"
module rrs_host_model (
  input wire logic clock,
  output logic [7:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // idle bus at time zero
  initial begin
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
  end
  // one transfer, held until pready is seen at an edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge clock);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // stale data does not linger
  endtask
  // one command bit per write
  task automatic cmd(input int b);
    logic [31:0] q;
    logic e;
    xfer(`RRS_OFF_CMD, 1'b1, 32'h1 << b, q, e);
  endtask
  task automatic rx_restart(input logic afc);
    cmd(afc ? `RRS_CMD_RELOCK : `RRS_CMD_NORELOCK);
  endtask
  task automatic seq_cmd(input logic stop);
    cmd(stop ? `RRS_CMD_STOP : `RRS_CMD_LAUNCH);
  endtask
endmodule

// file: verif/tb_rx_restart_and_mode_sequencer.sv
// bench for the restart engine and mode sequencer
`timescale 1ns/1ps
`include "rrs_defs.svh"
module tb_rx_restart_and_mode_sequencer
  import rrs_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [11:0] ev = 12'h0;
  logic fifo_empty = 1'b0;
  logic [7:0] rssi_level = 8'h00;
  logic [7:0] paddr, base, s;
  logic psel, penable, pwrite, pready, pslverr, rx_restart_pulse, rx_relock_pulse;
  logic mode_settled_flag;
  logic [31:0] pwdata, prdata;
  logic [31:0] seed = 32'h74c2e49f;
  logic [2:0] chip_mode;
  logic [6:0] seq_state;
  int n_errors = 0, tests_run = 0, cyc = 0, n_rs = 0, n_rl = 0, r0, r1, j;
  always #2 clock = ~clock;
  rrs_core #(.PLL_LOCK_CYC(20)) rrs_core_i (
    .clock, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .payload_complete_event(ev[0]), .fifo_empty,
    .fifo_threshold_irq(ev[1]), .packet_sent_irq(ev[2]), .crc_ok_irq(ev[3]),
    .rssi_irq(ev[4]), .sync_irq(ev[5]), .preamble_irq(ev[6]), .level_timeout(ev[7]),
    .preamble_timeout(ev[8]), .syncword_timeout(ev[9]), .first_interval_timer(ev[10]),
    .second_interval_timer(ev[11]), .rssi_level, .chip_mode, .rx_restart_pulse,
    .rx_relock_pulse, .mode_settled_flag, .seq_state
  );
  rrs_host_model rrs_host_model_i (
    .clock, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr
  );
  // pulse tallies and hang guard
  always @(posedge clock) begin
    n_rs <= n_rs + (rx_restart_pulse === 1'b1);
    n_rl <= n_rl + (rx_relock_pulse === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors = n_errors + 1;
      finish_test();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    tests_run = tests_run + 1;
    if (g !== x) begin
      n_errors = n_errors + 1;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    rrs_host_model_i.xfer(a, 1'b1, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    rrs_host_model_i.xfer(a, 1'b0, 32'h0, q, e);
    chk("rdata", x, q);
    chk("slverr", {31'h0, xe}, {31'h0, e});
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one-cycle event pulse
  task automatic fire(input int k);
    @(posedge clock);
    ev <= 12'h1 << k;
    @(posedge clock);
    ev <= 12'h0;
  endtask
  task automatic launch();
    rrs_host_model_i.seq_cmd(1'b0);
    wt(4);
  endtask
  initial begin
    wt(2);
    rst <= 1'b0;
    rd(`RRS_OFF_RXCFG, `RRS_RXCFG_RESET, 1'b0);
    rd(`RRS_OFF_SEQCFG, `RRS_SEQCFG_RESET, 1'b0);
    rd(`RRS_OFF_OPMODE, `RRS_OPMODE_RESET, 1'b0);
    rd(8'h14, 32'h0, 1'b1);
    rd(8'h06, 32'h0, 1'b1);
    chk("seq", RRS_SEQ_OFF, seq_state);
    $display("test reset done");
    // manual restarts, first one before the mode has settled
    wr(`RRS_OFF_OPMODE, {29'h0, `RRS_MODE_RX});
    rrs_host_model_i.rx_restart(1'b0);
    wt(4);
    chk("early", 0, n_rs);
    for (j = 0; j < 800 && mode_settled_flag !== 1'b1; j++) @(posedge clock);
    rrs_host_model_i.rx_restart(1'b0);
    wt(4);
    chk("norelock", 1, n_rs);
    rd(`RRS_OFF_CMD, 32'h0, 1'b0);
    for (j = 0; j < 800 && mode_settled_flag !== 1'b1; j++) @(posedge clock);
    rrs_host_model_i.rx_restart(1'b1);
    wt(4);
    chk("relock", 1, n_rl);
    $display("test manual done");
    // collision: disabled, rise equal to step, rise one above step
    seed = lfsr(seed);
    s = 8'h01 + {4'h0, seed[3:0]};
    base = {2'h0, seed[11:6]};
    for (j = 0; j < 3; j++) begin
      wr(`RRS_OFF_RXCFG, {16'h0, s, 8'h0} | (j > 0 ? 32'h4 : 32'h0));
      rssi_level <= base;
      wt(3);
      rssi_level <= base + s + {7'h0, j != 1};
      wt(3);
      chk("coll", 1 + (j == 2), n_rs);
    end
    rssi_level <= 8'h00;
    $display("test collision done");
    // auto rearm modes 00, 01, 10 with a 1 us gap
    for (j = 0; j < 3; j++) begin
      r0 = n_rs;
      r1 = n_rl;
      wr(`RRS_OFF_RXCFG, 32'h0001_0000 | j);
      fire(0);
      fifo_empty <= 1'b1;
      wt(2);
      fifo_empty <= 1'b0;
      wt(238);
      chk("gap", r0, n_rs);
      wt(30 + 20 * (j == 2));
      chk("rearm", r0 + (j == 1), n_rs);
      chk("rearm_lock", r1 + (j == 2), n_rl);
    end
    $display("test rearm done");
    // sequencer walk: launch, idle, receive, back to idle, then off
    wr(`RRS_OFF_OPMODE, 32'h1);
    wr(`RRS_OFF_SEQCFG, 32'h619);
    launch();
    chk("idle", RRS_SEQ_IDLE, seq_state);
    chk("idle_mode", `RRS_MODE_SLEEP, chip_mode);
    fire(11);
    wt(3);
    chk("idle_t2", RRS_SEQ_IDLE, seq_state);
    fire(10);
    wt(3);
    chk("rx", RRS_SEQ_RX, seq_state);
    fire(11);
    wt(3);
    chk("lp_idle", RRS_SEQ_IDLE, seq_state);
    wr(`RRS_OFF_SEQCFG, 32'h611);
    wr(`RRS_OFF_OPMODE, 32'h2);
    fire(10);
    wt(2);
    fire(11);
    wt(3);
    chk("off", RRS_SEQ_OFF, seq_state);
    chk("init", `RRS_MODE_STBY, chip_mode);
    // idle exit to transmit and receive, each stopped
    for (j = 0; j < 2; j++) begin
      wr(`RRS_OFF_SEQCFG, 32'h609 | (j << 4));
      launch();
      fire(10);
      wt(3);
      chk("exit", j ? RRS_SEQ_RX : RRS_SEQ_TX, seq_state);
      chk("exit_mode", j ? `RRS_MODE_RX : `RRS_MODE_TX, chip_mode);
      rrs_host_model_i.seq_cmd(1'b1);
      wt(3);
      chk("stop", RRS_SEQ_OFF, seq_state);
      wr(`RRS_OFF_OPMODE, 32'h1);
    end
    // each receive timeout ends the run
    wr(`RRS_OFF_SEQCFG, 32'h619);
    for (j = 7; j < 10; j++) begin
      launch();
      fire(10);
      wt(3);
      fire(j);
      wt(4);
      chk("rx_to", RRS_SEQ_OFF, seq_state);
      wr(`RRS_OFF_OPMODE, 32'h1);
    end
    // receive events end the run; from-start 11 waits for the fifo threshold
    for (j = 4; j < 7; j++) begin
      wr(`RRS_OFF_SEQCFG, 32'h19 | (j << 6));
      launch();
      fire(10);
      wt(3);
      fire(j);
      wt(4);
      chk("rx_ev", RRS_SEQ_OFF, seq_state);
    end
    wr(`RRS_OFF_SEQCFG, 32'h6);
    launch();
    chk("wait_thr", RRS_SEQ_OFF, seq_state);
    fire(1);
    wt(3);
    chk("thr_tx", RRS_SEQ_TX, seq_state);
    fire(2);
    wt(3);
    chk("sent_off", RRS_SEQ_OFF, seq_state);
    chk("sent_mode", `RRS_MODE_STBY, chip_mode);
    $display("test sequencer done");
    wr(`RRS_OFF_OPMODE, 32'h81);
    launch();
    chk("spread", RRS_SEQ_OFF, seq_state);
    $display("test spread done");
    finish_test();
  end
endmodule
